//--- pvp_pkg.sv
// Constants and types shared by the parallel video port
package pvp_pkg;
  // Register byte offsets
  localparam logic [5:0] CTRL_OFS  = 6'h00;
  localparam logic [5:0] DELAY_OFS = 6'h04;
  localparam logic [5:0] COUNT_OFS = 6'h08;
  localparam logic [5:0] LINE_OFS  = 6'h0C;
  localparam logic [5:0] FRAME_OFS = 6'h10;
  localparam logic [5:0] STAT_OFS  = 6'h14;
  // Control word fields
  localparam int unsigned EN_BIT  = 0;
  localparam int unsigned TX_BIT  = 1;
  localparam int unsigned ITU_BIT = 2;
  localparam int unsigned SUB_LSB = 3;
  localparam int unsigned WID_LSB = 5;
  localparam logic [15:0] CTRL_MASK = 16'h03FF;
  localparam logic [15:0] CTRL_RST  = 16'h0100;
  // Submodes
  localparam logic [1:0] GP_INPUT   = 2'h0;
  localparam logic [1:0] GP_CAPTURE = 2'h1;
  localparam logic [1:0] ITU_ACTIVE = 2'h0;
  localparam logic [1:0] ITU_VBI    = 2'h1;
  localparam logic [1:0] ITU_FIELD  = 2'h2;
  // Sample widths
  localparam logic [4:0] WID_8  = 5'h08;
  localparam logic [4:0] WID_10 = 5'h0A;
  localparam logic [4:0] WID_16 = 5'h10;
  // Reset values of the numeric registers
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] LINE_RST  = 16'h0010;
  localparam logic [15:0] FRAME_RST = 16'h0004;
  // Status bits
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_LOCK = 1;
  localparam int unsigned ST_OVR  = 2;
  localparam int unsigned ST_UND  = 3;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Embedded video timing codes
  localparam logic [7:0] CODE_FF = 8'hFF;
  localparam logic [7:0] CODE_00 = 8'h00;
  localparam int unsigned XY_F = 6;
  localparam int unsigned XY_V = 5;
  localparam int unsigned XY_H = 4;
  // Transfer sequencer states
  typedef enum logic [1:0] {
    PVP_IDLE  = 2'b00,
    PVP_DELAY = 2'b01,
    PVP_XFER  = 2'b10
  } pvp_state_e;
endpackage

//--- pvp_top.sv
// Parallel video port: pin front end, mode sequencer, video decoder, AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module pvp_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        port_clock,
  input  wire logic        frame_sync_one_in,
  output var  logic        frame_sync_one_out,
  output var  logic        frame_sync_one_oe,
  input  wire logic        frame_sync_two_in,
  output var  logic        frame_sync_two_out,
  output var  logic        frame_sync_two_oe,
  input  wire logic        frame_sync_three_in,
  output var  logic        frame_sync_three_out,
  output var  logic        frame_sync_three_oe,
  input  wire logic [15:0] pvp_data_in,
  output var  logic [15:0] pvp_data_out,
  output var  logic        pvp_data_oe,
  output var  logic        rx_valid,
  input  wire logic        rx_ready,
  output var  logic [15:0] rx_data,
  input  wire logic        tx_valid,
  output var  logic        tx_ready,
  input  wire logic [15:0] tx_data
);
  // Software-visible state
  logic [15:0] port_control_word_reg;
  logic [15:0] sync_delay_count_reg;
  logic [15:0] transfer_count_reg;
  logic [15:0] line_len_reg;
  logic [15:0] frame_lines_reg;
  logic        ovr_reg;
  logic        und_reg;

  // Mode decode
  logic       en;
  logic       tx_mode;
  logic       itu;
  logic [1:0] sub;
  logic [4:0] wid;
  logic       gp_in;
  logic       gp_cap;
  logic       gp_out;
  logic       itu_rx;
  logic       itu_tx;
  logic       gen_on;
  logic       seq_on;
  assign en      = port_control_word_reg[pvp_pkg::EN_BIT];
  assign tx_mode = port_control_word_reg[pvp_pkg::TX_BIT];
  assign itu     = port_control_word_reg[pvp_pkg::ITU_BIT];
  assign sub     = port_control_word_reg[pvp_pkg::SUB_LSB +: 2];
  assign wid     = port_control_word_reg[pvp_pkg::WID_LSB +: 5];
  // Half duplex: at most one direction is decoded at a time
  assign gp_in  = en & ~itu & ~tx_mode & (sub == pvp_pkg::GP_INPUT);
  assign gp_cap = en & ~itu & ~tx_mode & (sub == pvp_pkg::GP_CAPTURE);
  assign gp_out = en & ~itu & tx_mode;
  assign itu_rx = en & itu & ~tx_mode;
  assign itu_tx = en & itu & tx_mode;
  assign gen_on = gp_cap | gp_out;
  assign seq_on = gp_in | gen_on | itu_rx;

  // Width mask; unsupported codes fall back to the full bus in general-purpose modes, to ten bits in ITU modes
  logic        wid_ok;
  logic [15:0] wmask;
  logic [15:0] imask;
  assign wid_ok = (wid == pvp_pkg::WID_8) |
                  ((wid >= pvp_pkg::WID_10) & (wid <= pvp_pkg::WID_16));
  assign wmask  = wid_ok ? (16'hFFFF >> (pvp_pkg::WID_16 - wid)) : 16'hFFFF;
  assign imask  = (wid == pvp_pkg::WID_8) ? 16'h00FF : 16'h03FF;

  // Pin synchronisers; stage one feeds only stage two
  logic [2:0]  pclk_s;
  logic [2:0]  fs_s1;
  logic [2:0]  fs_s2;
  logic [15:0] din_s1;
  logic [15:0] din_s2;
  logic        pedge;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pclk_s <= 3'h0;
      fs_s1  <= 3'h0;
      fs_s2  <= 3'h0;
      din_s1 <= 16'h0000;
      din_s2 <= 16'h0000;
    end else begin
      pclk_s <= {pclk_s[1:0], port_clock};
      fs_s1  <= {frame_sync_three_in, frame_sync_two_in, frame_sync_one_in};
      fs_s2  <= fs_s1;
      din_s1 <= pvp_data_in;
      din_s2 <= din_s1;
    end
  end
  // Edge found by oversampling; needs at least two system clocks per port clock
  assign pedge = pclk_s[1] & ~pclk_s[2];

  // Frame sync one sampled at port clock edges in input mode
  logic fs1_prev;
  logic fs1_rise;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fs1_prev <= 1'b0;
    end else if (pedge) begin
      fs1_prev <= fs_s2[0];
    end
  end
  assign fs1_rise = pedge & gp_in & fs_s2[0] & ~fs1_prev;

  // Line and frame timing for modes where the device owns the syncs
  logic [15:0] h_cnt;
  logic [15:0] v_cnt;
  logic        h_last;
  logic        v_last;
  logic        frame_start;
  assign h_last = (h_cnt + 16'h0001) >= line_len_reg;
  assign v_last = (v_cnt + 16'h0001) >= frame_lines_reg;
  assign frame_start = pedge & gen_on & (h_cnt == 16'h0000) & (v_cnt == 16'h0000);
  always_ff @(posedge aclk) begin
    if (!aresetn || !gen_on) begin
      h_cnt <= 16'h0000;
      v_cnt <= 16'h0000;
    end else if (pedge) begin
      h_cnt <= h_last ? 16'h0000 : h_cnt + 16'h0001;
      if (h_last) begin
        v_cnt <= v_last ? 16'h0000 : v_cnt + 16'h0001;
      end
    end
  end

  // Sync pin drive: outputs only in capture and output modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_sync_one_out   <= 1'b0;
      frame_sync_two_out   <= 1'b0;
      frame_sync_three_out <= 1'b0;
      frame_sync_one_oe    <= 1'b0;
      frame_sync_two_oe    <= 1'b0;
      frame_sync_three_oe  <= 1'b0;
    end else begin
      frame_sync_one_oe   <= gen_on;
      frame_sync_two_oe   <= gen_on;
      frame_sync_three_oe <= gp_out;
      if (!gen_on) begin
        frame_sync_one_out   <= 1'b0;
        frame_sync_two_out   <= 1'b0;
        frame_sync_three_out <= 1'b0;
      end else if (pedge) begin
        frame_sync_one_out   <= (h_cnt == 16'h0000);
        frame_sync_two_out   <= (v_cnt == 16'h0000);
        frame_sync_three_out <= gp_out & (v_cnt == 16'h0000) & (h_cnt == 16'h0000);
      end
    end
  end

  // Embedded code decoder: FF 00 00 then the flag word
  logic [7:0] code;
  logic [1:0] pre_cnt;
  logic       is_xy;
  logic       f_reg;
  logic       v_reg;
  logic       act_reg;
  logic       lock_reg;
  logic       field1_start;
  logic       eav;
  assign code  = (wid == pvp_pkg::WID_8) ? din_s2[7:0] : din_s2[9:2];
  assign is_xy = (pre_cnt == 2'h3);
  assign field1_start = pedge & itu_rx & is_xy & ~code[pvp_pkg::XY_F] & f_reg;
  assign eav = pedge & itu_rx & is_xy & code[pvp_pkg::XY_H];
  always_ff @(posedge aclk) begin
    if (!aresetn || !itu_rx) begin
      pre_cnt  <= 2'h0;
      f_reg    <= 1'b0;
      v_reg    <= 1'b0;
      act_reg  <= 1'b0;
      lock_reg <= 1'b0;
    end else if (pedge) begin
      if (code == pvp_pkg::CODE_FF) begin
        pre_cnt <= 2'h1;
      end else if ((code == pvp_pkg::CODE_00) && (pre_cnt != 2'h0) && !is_xy) begin
        pre_cnt <= pre_cnt + 2'h1;
      end else begin
        pre_cnt <= 2'h0;
      end
      if (is_xy) begin
        f_reg   <= code[pvp_pkg::XY_F];
        v_reg   <= code[pvp_pkg::XY_V];
        // Active only from a start code outside vertical blanking
        act_reg <= ~code[pvp_pkg::XY_H] & ~code[pvp_pkg::XY_V];
      end
      if (field1_start) begin
        lock_reg <= 1'b1;
      end
    end
  end

  // Per-sample pass decision for the video submodes
  logic itu_pass;
  always_comb begin
    itu_pass = 1'b0;
    case (sub)
      pvp_pkg::ITU_ACTIVE: itu_pass = act_reg & ~is_xy & (code != pvp_pkg::CODE_FF) &
                                      (code != pvp_pkg::CODE_00);
      pvp_pkg::ITU_VBI:    itu_pass = v_reg;
      pvp_pkg::ITU_FIELD:  itu_pass = 1'b1;
      default:             itu_pass = 1'b0;
    endcase
  end

  // Trigger and unit of the transfer count for each mode
  logic trigger;
  logic unit;
  pvp_pkg::pvp_state_e st_reg;
  pvp_pkg::pvp_state_e st_next;
  logic [15:0] dly_left;
  logic [15:0] xfer_left;
  assign trigger = fs1_rise | frame_start | field1_start;
  always_comb begin
    unit = 1'b0;
    if (itu_rx && (sub == pvp_pkg::ITU_ACTIVE)) begin
      unit = eav & act_reg;
    end else if (itu_rx && (sub == pvp_pkg::ITU_VBI)) begin
      unit = eav & v_reg;
    end else begin
      unit = pedge;
    end
  end

  // Transfer sequencer
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      pvp_pkg::PVP_IDLE: begin
        if (trigger && (transfer_count_reg != 16'h0000)) begin
          st_next = (!itu_rx && (sync_delay_count_reg != 16'h0000)) ?
                    pvp_pkg::PVP_DELAY : pvp_pkg::PVP_XFER;
        end
      end
      pvp_pkg::PVP_DELAY: begin
        if (pedge && (dly_left == 16'h0001)) begin
          st_next = pvp_pkg::PVP_XFER;
        end
      end
      pvp_pkg::PVP_XFER: begin
        if (unit && (xfer_left == 16'h0001)) begin
          st_next = pvp_pkg::PVP_IDLE;
        end
      end
      default: st_next = pvp_pkg::PVP_IDLE;
    endcase
    if (!seq_on) begin
      st_next = pvp_pkg::PVP_IDLE;
    end
  end

  // Sequencer state and counters; counts reload while idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg    <= pvp_pkg::PVP_IDLE;
      dly_left  <= 16'h0000;
      xfer_left <= 16'h0000;
    end else begin
      st_reg <= st_next;
      if (st_reg == pvp_pkg::PVP_IDLE) begin
        dly_left  <= sync_delay_count_reg;
        xfer_left <= transfer_count_reg;
      end else begin
        if ((st_reg == pvp_pkg::PVP_DELAY) && pedge) begin
          dly_left <= dly_left - 16'h0001;
        end
        if ((st_reg == pvp_pkg::PVP_XFER) && unit) begin
          xfer_left <= xfer_left - 16'h0001;
        end
      end
    end
  end

  // Receive hand-off; a full slot drops the sample rather than stall the pins
  logic cap_now;
  logic ovr_set;
  assign cap_now = pedge & (st_reg == pvp_pkg::PVP_XFER) &
                   ((gp_in | gp_cap) | (itu_rx & itu_pass));
  assign ovr_set = cap_now & rx_valid & ~rx_ready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_valid <= 1'b0;
      rx_data  <= 16'h0000;
    end else if (cap_now && (!rx_valid || rx_ready)) begin
      rx_valid <= 1'b1;
      rx_data  <= din_s2 & (itu_rx ? imask : wmask);
    end else if (rx_ready) begin
      rx_valid <= 1'b0;
    end
  end

  // Transmit holding slot and pin drive
  logic        hold_full;
  logic [15:0] hold_data;
  logic        send_now;
  logic        und_set;
  assign send_now = pedge & (((st_reg == pvp_pkg::PVP_XFER) & gp_out) | itu_tx);
  assign und_set  = send_now & ~hold_full;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_full <= 1'b0;
      hold_data <= 16'h0000;
      tx_ready  <= 1'b0;
    end else if (tx_valid && tx_ready) begin
      hold_full <= 1'b1;
      hold_data <= tx_data;
      tx_ready  <= 1'b0;
    end else if (send_now && hold_full) begin
      hold_full <= 1'b0;
      tx_ready  <= 1'b1;
    end else begin
      tx_ready  <= ~hold_full;
    end
  end
  // An empty slot repeats the last sample and flags underflow
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pvp_data_out <= 16'h0000;
      pvp_data_oe  <= 1'b0;
    end else begin
      pvp_data_oe <= gp_out | itu_tx;
      if (send_now && hold_full) begin
        pvp_data_out <= hold_data & (itu_tx ? imask : wmask);
      end
    end
  end

  // AXI4-Lite write channel; address and data taken in either order
  logic [5:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  s_q;
  logic        wr_do;
  logic [5:0]  aw_word;
  assign wr_do   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign aw_word = {aw_q[5:2], 2'h0};
  function automatic logic [15:0] pvp_m16(input logic [15:0] o, input logic [31:0] d,
                                          input logic [3:0] st);
    pvp_m16 = {st[1] ? d[15:8] : o[15:8], st[0] ? d[7:0] : o[7:0]};
  endfunction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pvp_pkg::RESP_OKAY;
      aw_q <= 6'h00;
      w_q  <= 32'h0000_0000;
      s_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= s_axi_wdata;
        s_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= (aw_word <= pvp_pkg::STAT_OFS) ? pvp_pkg::RESP_OKAY :
                         pvp_pkg::RESP_SLVERR;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register stores
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_control_word_reg <= pvp_pkg::CTRL_RST;
      sync_delay_count_reg  <= pvp_pkg::DELAY_RST;
      transfer_count_reg    <= pvp_pkg::COUNT_RST;
      line_len_reg          <= pvp_pkg::LINE_RST;
      frame_lines_reg       <= pvp_pkg::FRAME_RST;
    end else if (wr_do) begin
      case (aw_word)
        pvp_pkg::CTRL_OFS:  port_control_word_reg <=
                              pvp_m16(port_control_word_reg, w_q, s_q) & pvp_pkg::CTRL_MASK;
        pvp_pkg::DELAY_OFS: sync_delay_count_reg <= pvp_m16(sync_delay_count_reg, w_q, s_q);
        pvp_pkg::COUNT_OFS: transfer_count_reg   <= pvp_m16(transfer_count_reg, w_q, s_q);
        pvp_pkg::LINE_OFS:  line_len_reg         <= pvp_m16(line_len_reg, w_q, s_q);
        pvp_pkg::FRAME_OFS: frame_lines_reg      <= pvp_m16(frame_lines_reg, w_q, s_q);
        default: ;
      endcase
    end
  end

  // Sticky flags, write one to clear; a new event beats the clear
  logic clr_hit;
  assign clr_hit = wr_do & (aw_word == pvp_pkg::STAT_OFS) & s_q[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovr_reg <= 1'b0;
      und_reg <= 1'b0;
    end else begin
      ovr_reg <= ovr_set | (ovr_reg & ~(clr_hit & w_q[pvp_pkg::ST_OVR]));
      und_reg <= und_set | (und_reg & ~(clr_hit & w_q[pvp_pkg::ST_UND]));
    end
  end

  // Read mux
  logic [31:0] rd_val;
  logic [15:0] stat_val;
  logic        rd_ok;
  assign stat_val = {12'h000, und_reg, ovr_reg, lock_reg,
                     (st_reg != pvp_pkg::PVP_IDLE) | itu_tx};
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case ({s_axi_araddr[5:2], 2'h0})
      pvp_pkg::CTRL_OFS:  rd_val = {16'h0000, port_control_word_reg};
      pvp_pkg::DELAY_OFS: rd_val = {16'h0000, sync_delay_count_reg};
      pvp_pkg::COUNT_OFS: rd_val = {16'h0000, transfer_count_reg};
      pvp_pkg::LINE_OFS:  rd_val = {16'h0000, line_len_reg};
      pvp_pkg::FRAME_OFS: rd_val = {16'h0000, frame_lines_reg};
      pvp_pkg::STAT_OFS:  rd_val = {16'h0000, stat_val};
      default:            rd_ok  = 1'b0;
    endcase
  end

  // AXI4-Lite read channel, one read under way at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pvp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_ok ? pvp_pkg::RESP_OKAY : pvp_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks
  default clocking pvp_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  port_edge_gap_a: assert property (pedge |=> !pedge)
    else $error("port clock edges closer than two system clocks");
  data_dir_a: assert property (pvp_data_oe |-> $past(tx_mode))
    else $error("data driven outside transmit");
  input_pins_free_a: assert property (gp_in |=> !frame_sync_one_oe && !pvp_data_oe)
    else $error("pin driven in input mode");
  capture_drive_a: assert property (gp_cap |=> frame_sync_one_oe && frame_sync_two_oe
                                    && !pvp_data_oe)
    else $error("frame capture pin directions wrong");
  delay_done_a: assert property ((st_reg == pvp_pkg::PVP_DELAY) ##1
                                 (st_reg == pvp_pkg::PVP_XFER) |->
                                 $past(dly_left) == 16'h0001)
    else $error("transfer began before delay ran out");
  count_step_a: assert property ((st_reg == pvp_pkg::PVP_XFER) && unit && seq_on |=>
                                 (xfer_left == $past(xfer_left) - 16'h0001) ||
                                 (st_reg == pvp_pkg::PVP_IDLE))
    else $error("transfer count did not step");
  code_filter_a: assert property (cap_now && itu_rx && (sub == pvp_pkg::ITU_ACTIVE) |->
                                  act_reg && (code != pvp_pkg::CODE_FF))
    else $error("control code passed in active mode");
  idle_quiet_a: assert property ((st_reg == pvp_pkg::PVP_IDLE) ##1 !cap_now |->
                                 !$rose(rx_valid))
    else $error("sample handed over while idle");
  rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("receive sample changed before taken");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  cover_input_frame_c: cover property (gp_in && (st_reg == pvp_pkg::PVP_XFER) ##1
                                       (st_reg == pvp_pkg::PVP_IDLE));
  cover_lock_c: cover property ($rose(lock_reg));
  cover_overflow_c: cover property (ovr_set);
  cover_output_c: cover property (send_now && hold_full && gp_out);
endmodule // pvp_top
`default_nettype wire

//--- pvp_src.sv
// Behavioural converter model: port clock, first sync and data pins
`timescale 1ns/1ps
`default_nettype none
module pvp_src (
  input  wire logic        run,
  input  wire logic        fs_req,
  output var  logic        pclk,
  output var  logic        fs_one,
  output var  logic [15:0] dat
);
  // Clock stands still between frames, 160 ns period while running
  initial begin
    pclk = 1'b0;
    forever #80 pclk = run ? ~pclk : 1'b0;
  end
  initial fs_one = 1'b0;
  initial dat = 16'h0000;
  // Pins move on the falling edge, far from the sampling edge; data restarts at sync rise
  always @(negedge pclk) begin
    fs_one <= fs_req;
    dat    <= (fs_req && !fs_one) ? 16'hAB00 : dat + 16'h0001;
  end
endmodule // pvp_src
`default_nettype wire

//--- parallel_video_data_port_tb.sv
// Register, general input capture and sync generator tests for the parallel video port
`timescale 1ns/1ps
`default_nettype none
module parallel_video_data_port_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic port_clock, fs1, run, fs_req, rx_valid, rx_ready, tx_ready;
  logic fs1_oe, fs2_oe, fs3_oe, data_oe, tx_valid;
  logic [15:0] pin_data, rx_data, data_out, tx_data;
  logic [15:0] q[$];
  int error_cnt = 0;
  int compares = 0;
  pvp_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .port_clock, .frame_sync_one_in(fs1), .frame_sync_one_out(),
    .frame_sync_one_oe(fs1_oe), .frame_sync_two_in(1'b0), .frame_sync_two_out(),
    .frame_sync_two_oe(fs2_oe), .frame_sync_three_in(1'b0), .frame_sync_three_out(),
    .frame_sync_three_oe(fs3_oe), .pvp_data_in(pin_data), .pvp_data_out(data_out),
    .pvp_data_oe(data_oe), .rx_valid, .rx_ready, .rx_data, .tx_valid, .tx_ready, .tx_data);
  pvp_src src (.run, .fs_req, .pclk(port_clock), .fs_one(fs1), .dat(pin_data));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Sample log in arrival order
  always @(posedge aclk) if (rx_valid === 1'b1 && rx_ready) q.push_back(rx_data);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Leading edge keeps a released ready from being raised twice in one step
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_t(input logic [5:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // One sync pulse, then count, values and silence afterwards
  task automatic cap(input logic [15:0] dly, cnt, ctl, first);
    int n;
    wr(pvp_pkg::CTRL_OFS, 32'h0000_0000);
    wr(pvp_pkg::DELAY_OFS, {16'h0000, dly});
    wr(pvp_pkg::COUNT_OFS, {16'h0000, cnt});
    wr(pvp_pkg::CTRL_OFS, {16'h0000, ctl});
    q = {};
    run <= 1'b1;
    repeat (100) @(posedge aclk);
    fs_req <= 1'b1;
    repeat (100) @(posedge aclk);
    fs_req <= 1'b0;
    n = 0;
    while (q.size() < cnt && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    repeat (400) @(posedge aclk);
    chk(32'(q.size()), {16'h0000, cnt});
    foreach (q[i]) chk({16'h0000, q[i]}, {16'h0000, first + 16'(i)});
    run <= 1'b0;
    $display("capture test done");
  endtask
  // Line timer owns the syncs; disabling first restarts it so a frame starts at once
  task automatic gen(input logic [15:0] ctl, input logic [31:0] n_exp, pins_exp);
    wr(pvp_pkg::CTRL_OFS, 32'h0000_0000);
    wr(pvp_pkg::COUNT_OFS, 32'h0000_0001);
    wr(pvp_pkg::CTRL_OFS, {16'h0000, ctl});
    q = {};
    run <= 1'b1;
    repeat (300) @(posedge aclk);
    chk(32'(q.size()), n_exp);
    chk({12'h000, fs1_oe, fs2_oe, fs3_oe, data_oe, data_out}, pins_exp);
    run <= 1'b0;
    $display("sync generator test done");
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog far beyond the few microseconds the tests need
  initial begin
    #100000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, run, fs_req, tx_valid} = '0;
    tx_data = 16'h00A5;
    s_axi_wstrb = 4'hF;
    rx_ready = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd_t(pvp_pkg::CTRL_OFS);
    chk(rd, {16'h0000, pvp_pkg::CTRL_RST});
    rd_t(pvp_pkg::LINE_OFS);
    chk(rd, {16'h0000, pvp_pkg::LINE_RST});
    rd_t(pvp_pkg::FRAME_OFS);
    chk(rd, {16'h0000, pvp_pkg::FRAME_RST});
    rd_t(6'h18);
    chk({30'h0, resp}, {30'h0, pvp_pkg::RESP_SLVERR});
    wr(6'h1C, 32'h0000_FFFF);
    chk({30'h0, resp}, {30'h0, pvp_pkg::RESP_SLVERR});
    wr(pvp_pkg::DELAY_OFS, 32'hFFFF_1234);
    rd_t(pvp_pkg::DELAY_OFS);
    chk(rd, 32'h0000_1234);
    $display("register test done");
    cap(16'h0001, 16'h0002, 16'h0101, 16'h0002);
    cap(16'h0000, 16'h0003, 16'h0201, 16'hAB01);
    cap(16'h0002, 16'h0001, 16'h0181, 16'h0B03);
    gen(16'h0109, 32'h0000_0001, 32'h000C_0000);
    tx_valid <= 1'b1;
    gen(16'h0103, 32'h0000_0000, 32'h000F_00A5);
    report_and_stop;
  end
endmodule // parallel_video_data_port_tb
`default_nettype wire
